// ### hw/aligner_defs.vh
`ifndef ALIGNER_DEFS_VH
`define ALIGNER_DEFS_VH

// Register byte addresses
`define ADDR_CTRL 12'h000
`define ADDR_PATTERN 12'h004
`define ADDR_STATUS 12'h008

// Control field positions
`define CTRL_WIDE10 0
`define CTRL_SLIP 1
`define CTRL_PAT7 2

// Reset values
`define CTRL_RESET 3'h0
`define PATTERN_RESET 16'h017c

// Status field positions
`define STAT_OFF_LSB 0
`define STAT_ARMED 4
`define STAT_CNT_LSB 8

// Word widths and boundary offsets
`define NARROW_W 8
`define WIDE_W 10
`define PAIR_W 16
`define OFF_W 4
`define OFF_MAX_NARROW 4'h7
`define OFF_MAX_WIDE 4'h9
`define OFF_ZERO 4'h0

// Pattern compare masks for the 10-bit path
`define MASK_PAT7 10'h07f
`define MASK_PAT10 10'h3ff

`endif

// ### hw/rise_detect.v
`timescale 1ns/1ps
module rise_detect
(
   input wire clk,
   input wire rst_b,
   input wire level,
   output wire rise
);

reg level_reg;

always @(posedge clk)
begin
   if (!rst_b)
      level_reg <= 1'b0;
   else
      level_reg <= level;
end

assign rise = level & ~level_reg;

endmodule // rise_detect

// ### hw/pattern_matcher.v
`timescale 1ns/1ps
module pattern_matcher
#(
   parameter W = 10,
   parameter SW = 30,
   parameter PW = 10,
   parameter BASE = 10
)
(
   input wire [SW-1:0] stream,
   input wire [PW-1:0] pattern,
   input wire [PW-1:0] mask,
   input wire accept_inv,
   output wire [W-1:0] hit
);

genvar k;
generate
   for (k = 0; k < W; k = k + 1)
   begin : g_off
      wire [PW-1:0] seg;
      wire same;
      wire inverted;
      assign seg = stream[BASE+k +: PW];
      assign same = ((seg ^ pattern) & mask) == {PW{1'b0}};
      assign inverted = ((~seg ^ pattern) & mask) == {PW{1'b0}};
      assign hit[k] = same | (accept_inv & inverted);
   end
endgenerate

endmodule // pattern_matcher

// ### hw/word_aligner.v
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "aligner_defs.vh"
module word_aligner
(
   input wire clk,
   input wire rst_b,
   input wire [9:0] data_in,
   input wire pattern_align_en,
   input wire bit_slip_req,
   output wire [9:0] data_out,
   output wire sync_pulse,
   output wire pattern_hit,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr
);

localparam NW = `NARROW_W;
localparam WW = `WIDE_W;

reg [2:0] ctrl_reg;
reg [15:0] pattern_reg;
reg [WW-1:0] prev_reg;
reg [WW-1:0] prev2_reg;
reg [`OFF_W-1:0] off_reg;
reg [`OFF_W-1:0] off_next;
reg armed_reg;
reg armed_next;
reg [7:0] update_cnt_reg;
reg [WW-1:0] data_out_reg;
reg sync_reg;
reg hit_reg;
reg [31:0] prdata_reg;
reg pready_reg;
reg pslverr_reg;
reg [31:0] rdata;
reg found;
reg [`OFF_W-1:0] found_off;
reg realign;
reg hit_now;
reg search_en;
integer i;

wire wide;
wire slip_mode;
wire pat7;
wire align_rise;
wire slip_rise;
wire [3*NW-1:0] stream8;
wire [3*WW-1:0] stream10;
wire [NW-1:0] hit8;
wire [WW-1:0] hit10;
wire [WW-1:0] hit_vec;
wire [WW-1:0] mask10;
wire [NW-1:0] word8;
wire [WW-1:0] word10;
wire [`OFF_W-1:0] off_max;
wire setup;
wire commit;
wire addr_ok;
wire pair_hit;
wire [2:0] off8;

assign wide = ctrl_reg[`CTRL_WIDE10];
assign slip_mode = ctrl_reg[`CTRL_SLIP];
assign pat7 = ctrl_reg[`CTRL_PAT7];
assign off_max = wide ? `OFF_MAX_WIDE : `OFF_MAX_NARROW;

// Oldest word at the bottom: bit 0 is the earliest bit received
assign stream8 = {data_in[NW-1:0], prev_reg[NW-1:0],
                  prev2_reg[NW-1:0]};
assign stream10 = {data_in, prev_reg, prev2_reg};

// Word history; cleared by the receive reset
always @(posedge clk)
begin
   if (!rst_b)
   begin
      prev_reg <= {WW{1'b0}};
      prev2_reg <= {WW{1'b0}};
   end
   else
   begin
      prev_reg <= data_in;
      prev2_reg <= prev_reg;
   end
end

// Strobes from user logic, edge detected
rise_detect align_edge
(
   .clk(clk),
   .rst_b(rst_b),
   .level(pattern_align_en),
   .rise(align_rise)
);

rise_detect slip_edge
(
   .clk(clk),
   .rst_b(rst_b),
   .level(bit_slip_req),
   .rise(slip_rise)
);

assign mask10 = pat7 ? `MASK_PAT7 : `MASK_PAT10;

// Two-word compare, earlier word as low byte
pattern_matcher
#(
   .W(NW),
   .SW(3*NW),
   .PW(`PAIR_W),
   .BASE(0)
)
match8
(
   .stream(stream8),
   .pattern(pattern_reg),
   .mask({`PAIR_W{1'b1}}),
   .accept_inv(1'b0),
   .hit(hit8)
);

// Complement accepted only in 10-bit pattern search, not in slip mode
pattern_matcher
#(
   .W(WW),
   .SW(3*WW),
   .PW(WW),
   .BASE(WW)
)
match10
(
   .stream(stream10),
   .pattern(pattern_reg[WW-1:0]),
   .mask(mask10),
   .accept_inv(~slip_mode),
   .hit(hit10)
);

assign hit_vec = wide ? hit10 : {{(WW-NW){1'b0}}, hit8};

// Lowest offset that holds the pattern
always @*
begin
   found = 1'b0;
   found_off = `OFF_ZERO;
   for (i = WW - 1; i >= 0; i = i - 1)
   begin
      if (hit_vec[i])
      begin
         found = 1'b1;
         found_off = i[`OFF_W-1:0];
      end
   end
end

// Next boundary and search state
always @*
begin
   if (slip_mode)
      search_en = 1'b0;
   else if (wide)
      search_en = pattern_align_en;
   else
      search_en = armed_reg | align_rise;
   realign = search_en & found & (found_off != off_reg);
   off_next = off_reg;
   if (realign)
      off_next = found_off;
   else if (slip_mode && slip_rise)
   begin
      if (off_reg >= off_max)
         off_next = `OFF_ZERO;
      else
         off_next = off_reg + 4'h1;
   end
   if (slip_mode || wide)
      armed_next = 1'b0;
   else
      armed_next = (armed_reg | align_rise) & ~found;
end

// Offsets past the 8-bit range fold back until the next slip or realign
assign off8 = off_next[2:0];
// Higher offset takes later bits, so the new bit enters at the msb
assign word8 = stream8[NW+off8 +: NW];
assign word10 = stream10[WW+off_next +: WW];

// Slip on 8-bit words: new word over the word sent just before it
assign pair_hit = {word8, data_out_reg[NW-1:0]} == pattern_reg;

always @*
begin
   if (slip_mode && !wide)
      hit_now = pair_hit;
   else
      hit_now = hit_vec[off_next];
end

// Data and status leave through one shared register stage
always @(posedge clk)
begin
   if (!rst_b)
   begin
      off_reg <= `OFF_ZERO;
      armed_reg <= 1'b0;
      data_out_reg <= {WW{1'b0}};
      sync_reg <= 1'b0;
      hit_reg <= 1'b0;
      update_cnt_reg <= 8'h00;
   end
   else
   begin
      off_reg <= off_next;
      armed_reg <= armed_next;
      data_out_reg <= wide ? word10 : {{(WW-NW){1'b0}}, word8};
      sync_reg <= realign;
      hit_reg <= hit_now;
      if (realign)
         update_cnt_reg <= update_cnt_reg + 8'h01;
   end
end

assign data_out = data_out_reg;
assign sync_pulse = sync_reg;
assign pattern_hit = hit_reg;

// APB slave, one cycle access phase
assign setup = psel & ~penable;
assign commit = psel & penable & pready_reg & pwrite;
assign addr_ok = (paddr == `ADDR_CTRL) || (paddr == `ADDR_PATTERN) ||
                 (paddr == `ADDR_STATUS);

// Register read mux
always @*
begin
   rdata = 32'h00000000;
   case (paddr)
      `ADDR_CTRL:
         rdata[2:0] = ctrl_reg;
      `ADDR_PATTERN:
         rdata[15:0] = pattern_reg;
      `ADDR_STATUS:
      begin
         rdata[`STAT_OFF_LSB +: `OFF_W] = off_reg;
         rdata[`STAT_ARMED] = armed_reg;
         rdata[`STAT_CNT_LSB +: 8] = update_cnt_reg;
      end
      default:
         rdata = 32'h00000000;
   endcase
end

// Writes land at the end of the access phase
always @(posedge clk)
begin
   if (!rst_b)
   begin
      ctrl_reg <= `CTRL_RESET;
      pattern_reg <= `PATTERN_RESET;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
   end
   else
   begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~addr_ok;
      prdata_reg <= (setup && !pwrite) ? rdata : 32'h00000000;
      if (commit && paddr == `ADDR_CTRL)
         ctrl_reg <= pwdata[2:0];
      if (commit && paddr == `ADDR_PATTERN)
         pattern_reg <= pwdata[15:0];
   end
end

assign prdata = prdata_reg;
assign pready = pready_reg;
assign pslverr = pslverr_reg;

endmodule // word_aligner

// ### tb/aligner_props.sv
`timescale 1ns/1ps
`include "aligner_defs.vh"
module aligner_props
(
   input wire clk,
   input wire rst_b,
   input wire [9:0] data_in,
   input wire pattern_align_en,
   input wire bit_slip_req,
   input wire [9:0] data_out,
   input wire sync_pulse,
   input wire pattern_hit,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr
);
   reg [1:0] ctrl_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Mode as last written over the bus
   always @(posedge clk)
   begin
      if (!rst_b)
         ctrl_reg <= 2'h0;
      else if (pready && pwrite && paddr == `ADDR_CTRL)
         ctrl_reg <= pwdata[1:0];
   end
   reset_clear_a:
      assert property (disable iff (1'b0) !rst_b |=> !sync_pulse
         && !pattern_hit && data_out == 10'h000) else $error("no clear");
   hit_sync_a:
      assert property (sync_pulse |-> pattern_hit) else $error("lone sync");
   sync_single_a:
      assert property (sync_pulse |=> !sync_pulse) else $error("long sync");
   hold_bound_a:
      assert property ((ctrl_reg == 2'h1 && !pattern_align_en) [*2]
         |=> !sync_pulse) else $error("moved while held");
   ready_next_a:
      assert property (psel && !penable |=> pready) else $error("no ready");
   ready_once_a:
      assert property (pready |=> !pready) else $error("long ready");
   err_map_a:
      assert property (pready |-> pslverr == !(paddr == `ADDR_CTRL
         || paddr == `ADDR_PATTERN || paddr == `ADDR_STATUS))
      else $error("bad slverr");
   idle_rdata_a:
      assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("stale read");
   sync_c: cover property (sync_pulse);
   hit_c: cover property (pattern_hit && !sync_pulse);
   err_c: cover property (pslverr);
endmodule // aligner_props
bind word_aligner aligner_props aligner_props_i (.clk, .rst_b, .data_in,
   .pattern_align_en, .bit_slip_req, .data_out, .sync_pulse, .pattern_hit,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

// ### tb/lane_user.sv
`timescale 1ns/1ps
module lane_user
(
   input wire clk,
   input wire [9:0] word,
   input wire hunt,
   input wire pattern_hit,
   output reg [9:0] data_in = 10'h000,
   output reg bit_slip_req = 1'b0
);
   reg [1:0] wait_reg = 2'h0;
   reg done_reg = 1'b0;
   // Slips every fourth cycle until a hit
   always @(posedge clk)
   begin
      data_in <= word;
      wait_reg <= wait_reg + 2'h1;
      done_reg <= hunt && (done_reg || pattern_hit === 1'b1);
      bit_slip_req <= hunt && !done_reg && pattern_hit !== 1'b1
         && wait_reg == 2'h3;
   end
endmodule // lane_user

// ### tb/word_aligner_test.sv
`timescale 1ns/1ps
`include "aligner_defs.vh"
module word_aligner_test;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg pattern_align_en = 1'b0;
   reg hunt = 1'b0;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   reg [9:0] word = 10'h000;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, rd;
   wire [9:0] data_in, data_out;
   wire bit_slip_req, sync_pulse, pattern_hit, pready, pslverr;
   wire [31:0] prdata;
   integer num_errors = 0, check_count = 0, syncs = 0;
   word_aligner word_aligner_i (.clk, .rst_b, .data_in, .pattern_align_en,
      .bit_slip_req, .data_out, .sync_pulse, .pattern_hit, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   lane_user lane_user_i (.clk, .word, .hunt, .pattern_hit, .data_in,
      .bit_slip_req);
   always #50 clk = ~clk;
   always @(posedge clk)
      syncs <= syncs + (sync_pulse === 1'b1);
   task chk(input [31:0] got, input [31:0] exp);
      check_count = check_count + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdchk(input [11:0] a, input [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task settle(input [9:0] w, input e);
      word <= w;
      repeat (5) @(posedge clk);
      pattern_align_en <= e;
      repeat (5) @(posedge clk);
   endtask
   task final_report;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #200000;
      num_errors = num_errors + 1;
      final_report;
   end
   initial
   begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      rdchk(`ADDR_CTRL, 32'h0);
      rdchk(`ADDR_PATTERN, `PATTERN_RESET);
      rdchk(`ADDR_STATUS, 32'h0);
      rdchk(12'h00c, 32'h0);
      chk(err, 1'b1);
      $display("reset done");
      apb(1'b1, `ADDR_CTRL, 32'h1);
      settle(10'h3e2, 1'b1);
      chk(data_out, 10'h17c);
      settle(10'h3e2, 1'b0);
      settle(10'h317, 1'b0);
      chk(syncs, 1);
      rdchk(`ADDR_STATUS, 32'h103);
      settle(10'h3e2, 1'b0);
      chk(pattern_hit, 1'b1);
      chk(syncs, 1);
      settle(10'h1d0, 1'b1);
      chk(data_out, 10'h283);
      rdchk(`ADDR_STATUS, 32'h207);
      $display("10-bit done");
      apb(1'b1, `ADDR_PATTERN, 32'h3c3c);
      apb(1'b1, `ADDR_CTRL, 32'h0);
      settle(10'h0f0, 1'b0);
      settle(10'h0f0, 1'b1);
      chk(data_out, 10'h03c);
      settle(10'h087, 1'b1);
      rdchk(`ADDR_STATUS, 32'h302);
      settle(10'h087, 1'b0);
      settle(10'h087, 1'b1);
      rdchk(`ADDR_STATUS, 32'h405);
      $display("8-bit done");
      apb(1'b1, `ADDR_PATTERN, 32'h0f1e);
      apb(1'b1, `ADDR_CTRL, 32'h2);
      word <= 10'h0f0;
      repeat (4) @(posedge clk);
      hunt <= 1'b1;
      repeat (60) @(posedge clk);
      chk(data_out, 10'h00f);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(rd[3:0], 4'h4);
      hunt <= 1'b0;
      $display("slip done");
      rst_b <= 1'b0;
      pattern_align_en <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rdchk(`ADDR_STATUS, 32'h0);
      rdchk(`ADDR_PATTERN, `PATTERN_RESET);
      $display("second reset done");
      final_report;
   end
endmodule // word_aligner_test
